// >>> verilog/prs_defs.svh
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
// register byte offsets
`define PRS_A_CTRL 8'h00
`define PRS_A_PSEL 8'h04
`define PRS_A_START 8'h08
`define PRS_A_DISP 8'h0c
`define PRS_A_MVRST 8'h10
`define PRS_A_MVMAN 8'h14
`define PRS_A_STBY 8'h18
`define PRS_A_SEGT 8'h1c
`define PRS_A_PASS 8'h20
`define PRS_A_CMD 8'h24
`define PRS_A_STAT 8'h28
`define PRS_A_POS 8'h2c
// register field positions
`define PRS_B_RUN 0
`define PRS_B_HOLD 1
`define PRS_B_RMODE 2
`define PRS_B_MANEN 3
`define PRS_B_MANUAL 4
`define PRS_B_AT 5
`define PRS_B_REMOTE 6
`define PRS_B_HC 7
`define PRS_B_PP 8
`define PRS_B_MVSEL 4
`define PRS_B_CMD_SU 0
// reset values and passcode
`define PRS_R_DISP 3'h3
`define PRS_R_START 2'h0
`define PRS_R_STBY 16'h0000
`define PRS_R_SEGT 16'h0010
`define PRS_PASSCODE 16'hff57
// timing
`define PRS_CLK_KHZ 250000
`define PRS_KEY_LONG_MS 3000
`define PRS_KEY_SHORT_MS 1000
`define PRS_IDLE_MS 2000
`define PRS_TICK_CYC 8'hfa
`endif

// >>> verilog/prs_pkg.sv
package prs_pkg;
   typedef enum logic [2:0] {
      PRS_ST_RESET = 3'b001,
      PRS_ST_RUN = 3'b010,
      PRS_ST_HOLD = 3'b100
   } prs_run_t;
   typedef enum logic [2:0] {
      PRS_LV_OPER = 3'b001,
      PRS_LV_INIT = 3'b010,
      PRS_LV_ADV = 3'b100
   } prs_lvl_t;
   typedef enum logic [1:0] {
      PRS_SU_CONT = 2'h0,
      PRS_SU_RESET = 2'h1,
      PRS_SU_RUN = 2'h2,
      PRS_SU_MANUAL = 2'h3
   } prs_start_t;
   typedef enum logic [1:0] {
      PRS_LN_NONE = 2'h0,
      PRS_LN_PROGSEG = 2'h1,
      PRS_LN_MV = 2'h2,
      PRS_LN_REM = 2'h3
   } prs_line_t;
   typedef enum logic [1:0] {
      PRS_SP_PROG = 2'h0,
      PRS_SP_FIXED = 2'h1,
      PRS_SP_REMOTE = 2'h2
   } prs_spm_t;
endpackage : prs_pkg

// >>> verilog/prs_seq.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "prs_defs.svh"
// Behaviour
// R1: run setting starts program execution; reset setting stops it.
// R2: hold suspends program progress until hold is cleared.
// R3: program number change accepted only in reset status, else refused.
// R4: entering reset zeroes segment, time, repetitions; clears hold, loads program, cancels tuning.
// R5: stop-control reset halts regulation and outputs the reset manipulated value.
// R6: fixed set-point reset behaviour: run always enters program set-point mode.
// R7: fixed set-point reset behaviour: reset moves to fixed/remote set point, keeps regulating.
// R8: fixed set-point reset behaviour makes segment 0 a ramp from active set point.
// R9: four-way startup choice: continue, reset, run from start, manual.
// R10: startup also applied on software reset and return to operation level.
// R11: run startup restarts program, standby included, from first segment.
// R12: continue/manual keep progress state; reset/run keep program, auto/manual, manual value.
// R13: manual startup choice refused while manual operation is disabled.
// R14: run startup reloads remaining standby with full standby time.
// R15: manual startup from auto: reset outputs manual value, or 0 in fixed mode.
// R16: display selection 0..7 chooses third-line content.
// R17: display selection defaults to 3, program and segment number.
// R18: selections 1,2,5,6: each mode key press swaps the third-line content.
// R19: heat/cool with value shown: selector picks heating or cooling value, only then.
// R20: position-proportional variant shows valve-opening value.
// R21: advanced level needs code -169, then key press or two idle seconds.
// R22: key held three seconds enters initial level; one second steps back.
// R23: transitions evaluated synchronously, one state change per control tick.
module prs_seq #(
   parameter logic [31:0] KEY_LONG_CYC = `PRS_KEY_LONG_MS * `PRS_CLK_KHZ,
   parameter logic [31:0] KEY_SHORT_CYC = `PRS_KEY_SHORT_MS * `PRS_CLK_KHZ,
   parameter logic [31:0] IDLE_CYC = `PRS_IDLE_MS * `PRS_CLK_KHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic level_key_n,
   input wire logic mode_key_n,
   input wire logic [15:0] pid_mv,
   input wire logic [15:0] cool_mv,
   input wire logic [15:0] valve_mv,
   output logic ctrl_on,
   output logic [15:0] mv_out,
   output logic [1:0] sp_mode,
   output logic seg0_ramp,
   output logic autotune_cancel,
   output logic [1:0] third_line_content_select,
   output logic [15:0] third_line_value,
   output logic [2:0] menu_level
);
   function automatic logic prs_known(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= `PRS_A_POS;
   endfunction : prs_known

   function automatic prs_pkg::prs_line_t prs_line(input logic [2:0] d, input logic alt);
      unique case (d)
         3'h1: return alt ? prs_pkg::PRS_LN_MV : prs_pkg::PRS_LN_PROGSEG;
         3'h2: return alt ? prs_pkg::PRS_LN_PROGSEG : prs_pkg::PRS_LN_MV;
         3'h3: return prs_pkg::PRS_LN_PROGSEG;
         3'h4: return prs_pkg::PRS_LN_MV;
         3'h5: return alt ? prs_pkg::PRS_LN_REM : prs_pkg::PRS_LN_PROGSEG;
         3'h6: return alt ? prs_pkg::PRS_LN_REM : prs_pkg::PRS_LN_MV;
         3'h7: return prs_pkg::PRS_LN_REM;
         default: return prs_pkg::PRS_LN_NONE;
      endcase
   endfunction : prs_line

   logic key_s1_r, key_s2_r, key_d_r, mkey_s1_r, mkey_s2_r, mkey_d_r;
   logic [8:0] ctl_r, ctl_nxt;
   logic [2:0] psel_r, psel_nxt, prog_r, prog_nxt, disp_r, disp_nxt;
   logic [1:0] start_r, start_nxt;
   logic mvsel_r, mvsel_nxt;
   logic [15:0] mvrst_r, mvrst_nxt, mvman_r, mvman_nxt, stby_r, stby_nxt, segt_r, segt_nxt;
   prs_pkg::prs_run_t st_r, st_nxt;
   logic [4:0] seg_r, seg_nxt;
   logic [15:0] el_r, el_nxt, segel_r, segel_nxt, stleft_r, stleft_nxt;
   logic [7:0] reps_r, reps_nxt;
   logic from_auto_r, from_auto_nxt, su_pend_r, su_pend_nxt, atc_r, atc_nxt;
   logic [7:0] tick_cnt_r, tick_cnt_nxt;
   logic tick;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic setup, wr, wr_pass;
   prs_pkg::prs_lvl_t lvl_r, lvl_nxt;
   logic [31:0] keycnt_r, keycnt_nxt, idle_r, idle_nxt;
   logic wrel_r, wrel_nxt, pw_ok_r, pw_ok_nxt, alt_r, alt_nxt, lv_ret;
   logic ctrl_on_r, ctrl_on_nxt, seg0_r, seg0_nxt;
   logic [15:0] mv_r, mv_nxt, tlv_r, tlv_nxt;
   logic [1:0] spm_r, spm_nxt;
   prs_pkg::prs_line_t line_r, line_nxt;

   assign setup = psel && !penable;
   assign wr = psel && penable && pready_r && pwrite;
   assign wr_pass = wr && paddr == `PRS_A_PASS;
   assign tick = tick_cnt_r == 8'h00;

   // panel keys arrive asynchronously
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_s1_r <= 1'b1;
         key_s2_r <= 1'b1;
         key_d_r <= 1'b1;
         mkey_s1_r <= 1'b1;
         mkey_s2_r <= 1'b1;
         mkey_d_r <= 1'b1;
      end else begin
         key_s1_r <= level_key_n;
         key_s2_r <= key_s1_r;
         key_d_r <= key_s2_r;
         mkey_s1_r <= mode_key_n;
         mkey_s2_r <= mkey_s1_r;
         mkey_d_r <= mkey_s2_r;
      end
   end

   // bus, configuration and program sequencing
   always_comb begin
      ctl_nxt = ctl_r;
      psel_nxt = psel_r;
      start_nxt = start_r;
      disp_nxt = disp_r;
      mvsel_nxt = mvsel_r;
      mvrst_nxt = mvrst_r;
      mvman_nxt = mvman_r;
      stby_nxt = stby_r;
      segt_nxt = segt_r;
      prog_nxt = prog_r;
      st_nxt = st_r;
      seg_nxt = seg_r;
      el_nxt = el_r;
      segel_nxt = segel_r;
      stleft_nxt = stleft_r;
      reps_nxt = reps_r;
      from_auto_nxt = from_auto_r;
      atc_nxt = 1'b0;
      su_pend_nxt = su_pend_r;
      tick_cnt_nxt = tick ? `PRS_TICK_CYC - 8'h01 : tick_cnt_r - 8'h01;
      pready_nxt = setup;
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (setup) begin
         pslverr_nxt = !prs_known(paddr);
         if (pwrite && paddr == `PRS_A_PSEL && st_r != prs_pkg::PRS_ST_RESET)
            pslverr_nxt = 1'b1; // R3
         if (pwrite && paddr == `PRS_A_START && pwdata[1:0] == prs_pkg::PRS_SU_MANUAL && !ctl_r[`PRS_B_MANEN])
            pslverr_nxt = 1'b1; // R13
         unique case (paddr)
            `PRS_A_CTRL: prdata_nxt = {23'h0, ctl_r};
            `PRS_A_PSEL: prdata_nxt = {29'h0, psel_r};
            `PRS_A_START: prdata_nxt = {30'h0, start_r};
            `PRS_A_DISP: prdata_nxt = {27'h0, mvsel_r, 1'b0, disp_r};
            `PRS_A_MVRST: prdata_nxt = {16'h0, mvrst_r};
            `PRS_A_MVMAN: prdata_nxt = {16'h0, mvman_r};
            `PRS_A_STBY: prdata_nxt = {16'h0, stby_r};
            `PRS_A_SEGT: prdata_nxt = {16'h0, segt_r};
            `PRS_A_STAT: prdata_nxt = {16'h0, stleft_r[3:0], 1'b0, lvl_r, line_r, 1'b0, su_pend_r, from_auto_r, st_r};
            `PRS_A_POS: prdata_nxt = {reps_r, prog_r, seg_r, el_r};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
      if (wr && !pslverr_r) begin
         unique case (paddr)
            `PRS_A_CTRL: ctl_nxt = pwdata[8:0];
            `PRS_A_PSEL: psel_nxt = pwdata[2:0]; // R3
            `PRS_A_START: start_nxt = pwdata[1:0];
            `PRS_A_DISP: begin
               disp_nxt = pwdata[2:0]; // R16
               // selector offered only for heat/cool with the value on show
               if (ctl_r[`PRS_B_HC] && line_r == prs_pkg::PRS_LN_MV)
                  mvsel_nxt = pwdata[`PRS_B_MVSEL]; // R19
            end
            `PRS_A_MVRST: mvrst_nxt = pwdata[15:0];
            `PRS_A_MVMAN: mvman_nxt = pwdata[15:0];
            `PRS_A_STBY: stby_nxt = pwdata[15:0];
            `PRS_A_SEGT: segt_nxt = pwdata[15:0];
            default: ;
         endcase
      end
      // set wins: a new startup request in the consuming tick stays pending
      if (tick && su_pend_r)
         su_pend_nxt = 1'b0;
      if ((wr && paddr == `PRS_A_CMD && pwdata[`PRS_B_CMD_SU]) || lv_ret)
         su_pend_nxt = 1'b1; // R10
      if (tick) begin // R23
         if (su_pend_r) begin // R9
            unique case (start_r)
               prs_pkg::PRS_SU_RESET: begin
                  ctl_nxt[`PRS_B_RUN] = 1'b0;
                  ctl_nxt[`PRS_B_HOLD] = 1'b0; // R12
                  st_nxt = prs_pkg::PRS_ST_RESET;
                  seg_nxt = 5'h00;
                  el_nxt = 16'h0000;
                  segel_nxt = 16'h0000;
                  reps_nxt = 8'h00;
                  stleft_nxt = stby_r;
                  prog_nxt = psel_r;
                  // startup into reset is a reset entry too, so tuning is cancelled
                  ctl_nxt[`PRS_B_AT] = 1'b0; // R4
                  atc_nxt = 1'b1; // R4
               end
               prs_pkg::PRS_SU_RUN: begin
                  ctl_nxt[`PRS_B_RUN] = 1'b1;
                  ctl_nxt[`PRS_B_HOLD] = 1'b0;
                  st_nxt = prs_pkg::PRS_ST_RUN; // R11
                  seg_nxt = 5'h00;
                  el_nxt = 16'h0000;
                  segel_nxt = 16'h0000;
                  reps_nxt = 8'h00;
                  stleft_nxt = stby_r; // R14
               end
               prs_pkg::PRS_SU_MANUAL: begin
                  from_auto_nxt = !ctl_r[`PRS_B_MANUAL]; // R15
                  ctl_nxt[`PRS_B_MANUAL] = 1'b1; // R12
               end
               default: ;
            endcase
         end else if (ctl_r[`PRS_B_RUN] && st_r == prs_pkg::PRS_ST_RESET) begin
            st_nxt = prs_pkg::PRS_ST_RUN; // R1
            from_auto_nxt = 1'b0;
         end else if (!ctl_r[`PRS_B_RUN] && st_r != prs_pkg::PRS_ST_RESET) begin
            st_nxt = prs_pkg::PRS_ST_RESET; // R1
            seg_nxt = 5'h00; // R4
            el_nxt = 16'h0000;
            segel_nxt = 16'h0000;
            reps_nxt = 8'h00;
            stleft_nxt = stby_r;
            ctl_nxt[`PRS_B_HOLD] = 1'b0;
            ctl_nxt[`PRS_B_AT] = 1'b0;
            prog_nxt = psel_r;
            atc_nxt = 1'b1;
         end else if (st_r == prs_pkg::PRS_ST_RUN && ctl_r[`PRS_B_HOLD]) begin
            st_nxt = prs_pkg::PRS_ST_HOLD; // R2
         end else if (st_r == prs_pkg::PRS_ST_HOLD && !ctl_r[`PRS_B_HOLD]) begin
            st_nxt = prs_pkg::PRS_ST_RUN; // R2
         end else if (st_r == prs_pkg::PRS_ST_RUN) begin
            if (stleft_r != 16'h0000) begin
               stleft_nxt = stleft_r - 16'h0001;
            end else begin
               el_nxt = el_r + 16'h0001;
               if (segel_r + 16'h0001 >= segt_r) begin
                  segel_nxt = 16'h0000;
                  seg_nxt = seg_r + 5'h01;
                  if (seg_r == 5'h1f)
                     reps_nxt = reps_r + 8'h01;
               end else begin
                  segel_nxt = segel_r + 16'h0001;
               end
            end
         end
      end
      if (st_r == prs_pkg::PRS_ST_RESET && !su_pend_r)
         prog_nxt = psel_r; // R4
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= 9'h000;
         psel_r <= 3'h0;
         start_r <= `PRS_R_START;
         disp_r <= `PRS_R_DISP; // R17
         mvsel_r <= 1'b0;
         mvrst_r <= 16'h0000;
         mvman_r <= 16'h0000;
         stby_r <= `PRS_R_STBY;
         segt_r <= `PRS_R_SEGT;
         prog_r <= 3'h0;
         st_r <= prs_pkg::PRS_ST_RESET;
         seg_r <= 5'h00;
         el_r <= 16'h0000;
         segel_r <= 16'h0000;
         stleft_r <= 16'h0000;
         reps_r <= 8'h00;
         from_auto_r <= 1'b0;
         su_pend_r <= 1'b0;
         atc_r <= 1'b0;
         tick_cnt_r <= 8'h00;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         psel_r <= psel_nxt;
         start_r <= start_nxt;
         disp_r <= disp_nxt;
         mvsel_r <= mvsel_nxt;
         mvrst_r <= mvrst_nxt;
         mvman_r <= mvman_nxt;
         stby_r <= stby_nxt;
         segt_r <= segt_nxt;
         prog_r <= prog_nxt;
         st_r <= st_nxt;
         seg_r <= seg_nxt;
         el_r <= el_nxt;
         segel_r <= segel_nxt;
         stleft_r <= stleft_nxt;
         reps_r <= reps_nxt;
         from_auto_r <= from_auto_nxt;
         su_pend_r <= su_pend_nxt;
         atc_r <= atc_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // front-panel level walk
   always_comb begin
      lvl_nxt = lvl_r;
      wrel_nxt = wrel_r;
      pw_ok_nxt = pw_ok_r;
      alt_nxt = alt_r;
      lv_ret = 1'b0;
      keycnt_nxt = key_s2_r ? 32'h0 : (keycnt_r == 32'hffff_ffff ? keycnt_r : keycnt_r + 32'h1);
      idle_nxt = !key_s2_r ? 32'h0 : (idle_r == 32'hffff_ffff ? idle_r : idle_r + 32'h1);
      // a long hold must be released before it counts again
      if (key_s2_r)
         wrel_nxt = 1'b0;
      if (!mkey_s2_r && mkey_d_r && (disp_r == 3'h1 || disp_r == 3'h2 || disp_r == 3'h5 || disp_r == 3'h6))
         alt_nxt = !alt_r; // R18
      if (wr && paddr == `PRS_A_DISP)
         alt_nxt = 1'b0;
      unique case (lvl_r)
         prs_pkg::PRS_LV_OPER: begin
            if (!key_s2_r && !wrel_r && keycnt_r >= KEY_LONG_CYC - 32'h1) begin
               lvl_nxt = prs_pkg::PRS_LV_INIT; // R22
               wrel_nxt = 1'b1;
               pw_ok_nxt = 1'b0;
            end
         end
         prs_pkg::PRS_LV_INIT: begin
            if (wr_pass)
               pw_ok_nxt = pwdata[15:0] == `PRS_PASSCODE; // R21
            if (!key_s2_r && !wrel_r && keycnt_r >= KEY_SHORT_CYC - 32'h1) begin
               lvl_nxt = prs_pkg::PRS_LV_OPER; // R22
               wrel_nxt = 1'b1;
               pw_ok_nxt = 1'b0;
               lv_ret = 1'b1; // R10
            end else if (pw_ok_r && ((!key_s2_r && key_d_r) || idle_r >= IDLE_CYC - 32'h1)) begin
               lvl_nxt = prs_pkg::PRS_LV_ADV; // R21
               pw_ok_nxt = 1'b0;
            end
         end
         prs_pkg::PRS_LV_ADV: begin
            if (!key_s2_r && !wrel_r && keycnt_r >= KEY_SHORT_CYC - 32'h1) begin
               lvl_nxt = prs_pkg::PRS_LV_INIT; // R22
               wrel_nxt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_r <= prs_pkg::PRS_LV_OPER;
         wrel_r <= 1'b0;
         pw_ok_r <= 1'b0;
         alt_r <= 1'b0;
         keycnt_r <= 32'h0;
         idle_r <= 32'h0;
      end else begin
         lvl_r <= lvl_nxt;
         wrel_r <= wrel_nxt;
         pw_ok_r <= pw_ok_nxt;
         alt_r <= alt_nxt;
         keycnt_r <= keycnt_nxt;
         idle_r <= idle_nxt;
      end
   end

   // control outputs and third line
   always_comb begin
      ctrl_on_nxt = !(st_r == prs_pkg::PRS_ST_RESET && !ctl_r[`PRS_B_RMODE]); // R5 R7
      seg0_nxt = ctl_r[`PRS_B_RMODE]; // R8
      if (st_r != prs_pkg::PRS_ST_RESET)
         spm_nxt = prs_pkg::PRS_SP_PROG; // R6
      else
         spm_nxt = ctl_r[`PRS_B_REMOTE] ? prs_pkg::PRS_SP_REMOTE : prs_pkg::PRS_SP_FIXED; // R7
      if (ctl_r[`PRS_B_MANUAL])
         mv_nxt = (st_r == prs_pkg::PRS_ST_RESET && ctl_r[`PRS_B_RMODE] && from_auto_r) ? 16'h0000 : mvman_r; // R15
      else if (st_r == prs_pkg::PRS_ST_RESET && !ctl_r[`PRS_B_RMODE])
         mv_nxt = mvrst_r; // R5
      else
         mv_nxt = pid_mv;
      line_nxt = prs_line(disp_r, alt_r); // R16
      unique case (line_r)
         prs_pkg::PRS_LN_PROGSEG: tlv_nxt = {5'h00, prog_r, 3'h0, seg_r};
         prs_pkg::PRS_LN_MV: tlv_nxt = ctl_r[`PRS_B_PP] ? valve_mv : // R20
            ((ctl_r[`PRS_B_HC] && mvsel_r) ? cool_mv : mv_r); // R19
         prs_pkg::PRS_LN_REM: tlv_nxt = segt_r - segel_r;
         default: tlv_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_on_r <= 1'b0;
         seg0_r <= 1'b0;
         spm_r <= 2'h1;
         mv_r <= 16'h0000;
         line_r <= prs_pkg::PRS_LN_PROGSEG;
         tlv_r <= 16'h0000;
      end else begin
         ctrl_on_r <= ctrl_on_nxt;
         seg0_r <= seg0_nxt;
         spm_r <= spm_nxt;
         mv_r <= mv_nxt;
         line_r <= line_nxt;
         tlv_r <= tlv_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ctrl_on = ctrl_on_r;
   assign mv_out = mv_r;
   assign sp_mode = spm_r;
   assign seg0_ramp = seg0_r;
   assign autotune_cancel = atc_r;
   assign third_line_content_select = line_r;
   assign third_line_value = tlv_r;
   assign menu_level = lvl_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   prog_refused_a: assert property ( // R3
      setup && pwrite && paddr == `PRS_A_PSEL && st_r != prs_pkg::PRS_ST_RESET ##1 penable
      |=> $stable(psel_r)) else $error("program select changed outside reset");
   reset_clear_a: assert property ( // R4
      $fell(st_r == prs_pkg::PRS_ST_RUN || st_r == prs_pkg::PRS_ST_HOLD)
      |-> seg_r == 5'h00 && el_r == 16'h0000 && reps_r == 8'h00 && !ctl_r[`PRS_B_HOLD] && atc_r)
      else $error("reset entry did not clear progress");
   stop_mv_a: assert property ( // R5
      st_r == prs_pkg::PRS_ST_RESET && !ctl_r[`PRS_B_RMODE] && !ctl_r[`PRS_B_MANUAL] && $stable(mvrst_r)
      |=> !ctrl_on && mv_out == $past(mvrst_r)) else $error("stop reset output wrong");
   run_prog_sp_a: assert property ( // R6
      st_r == prs_pkg::PRS_ST_RUN |=> sp_mode == prs_pkg::PRS_SP_PROG) else $error("run not in program sp");
   fixed_keeps_a: assert property ( // R7
      st_r == prs_pkg::PRS_ST_RESET && ctl_r[`PRS_B_RMODE] |=> ctrl_on && sp_mode != prs_pkg::PRS_SP_PROG)
      else $error("fixed reset stopped control");
   run_startup_a: assert property ( // R11
      tick && su_pend_r && start_r == prs_pkg::PRS_SU_RUN
      |=> st_r == prs_pkg::PRS_ST_RUN && seg_r == 5'h00 && stleft_r == $past(stby_r)) // R14
      else $error("run startup did not restart");
   manual_refused_a: assert property ( // R13
      setup && pwrite && paddr == `PRS_A_START && pwdata[1:0] == 2'h3 && !ctl_r[`PRS_B_MANEN] ##1 penable
      |-> pslverr ##1 start_r == $past(start_r, 2)) else $error("manual startup accepted");
   mode_toggle_a: assert property ( // R18
      !mkey_s2_r && mkey_d_r && disp_r == 3'h1 && !(wr && paddr == `PRS_A_DISP) |=> alt_r != $past(alt_r))
      else $error("mode key did not swap line");
   adv_needs_code_a: assert property ( // R21
      lvl_r == prs_pkg::PRS_LV_INIT ##1 lvl_r == prs_pkg::PRS_LV_ADV |-> $past(pw_ok_r))
      else $error("advanced level without code");
   one_step_a: assert property ( // R23
      !$past(tick) |-> $stable(st_r)) else $error("state changed off tick");
   cov_run_c: cover property (st_r == prs_pkg::PRS_ST_RESET ##[1:300] st_r == prs_pkg::PRS_ST_RUN);
   cov_hold_c: cover property (st_r == prs_pkg::PRS_ST_HOLD ##[1:300] st_r == prs_pkg::PRS_ST_RUN);
   cov_adv_c: cover property (lvl_r == prs_pkg::PRS_LV_ADV);
endmodule : prs_seq

// >>> verif/prs_panel.sv
`timescale 1ns/1ns
module prs_panel (
   input wire logic lvl_cmd,
   input wire logic mode_cmd,
   output logic level_key_n,
   output logic mode_key_n,
   output logic [15:0] pid_mv,
   output logic [15:0] cool_mv,
   output logic [15:0] valve_mv
);
   // keys are pulled up, so a released key reads high
   assign level_key_n = !lvl_cmd;
   assign mode_key_n = !mode_cmd;
   // distinct values so a wrong selection cannot match by chance
   assign pid_mv = 16'h1111;
   assign cool_mv = 16'h2222;
   assign valve_mv = 16'h3333;
endmodule : prs_panel

// >>> verif/tb_program_run_reset_sequencer.sv
`timescale 1ns/1ns
`include "prs_defs.svh"
module tb_program_run_reset_sequencer;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lvl, mode, lk_n, mk_n, ctrl_on, seg0, atc;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] pid, cool, valve, mv_out, tlv;
   logic [1:0] sp_mode, tls;
   logic [2:0] menu_level;
   integer n_fail = 0;
   integer num_checks = 0;
   integer i;
   integer n_atc = 0;
   // the cancel pulse stands one cycle, so it is counted rather than polled
   always @(posedge pclk)
      if (atc === 1'b1)
         n_atc <= n_atc + 1;
   localparam logic [15:0] M0 = 16'he664;
   localparam logic [15:0] M1 = 16'hfe58;
   prs_seq #(.KEY_LONG_CYC(32'h28), .KEY_SHORT_CYC(32'h14), .IDLE_CYC(32'h1e)) i_prs_seq (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .level_key_n(lk_n), .mode_key_n(mk_n),
      .pid_mv(pid), .cool_mv(cool), .valve_mv(valve), .ctrl_on(ctrl_on), .mv_out(mv_out),
      .sp_mode(sp_mode), .seg0_ramp(seg0), .autotune_cancel(atc), .third_line_content_select(tls),
      .third_line_value(tlv), .menu_level(menu_level));
   prs_panel i_prs_panel (.lvl_cmd(lvl), .mode_cmd(mode), .level_key_n(lk_n), .mode_key_n(mk_n),
      .pid_mv(pid), .cool_mv(cool), .valve_mv(valve));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task cyc(input integer n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // one apb transfer; pslverr compared with the expected refusal
   task ap(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe);
      integer k;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         do begin
            @(posedge pclk);
            k++;
         end while (pready !== 1'b1 && k < 16);
         if (pready !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, pready, 1'b1);
            final_report();
         end
         rdat = prdata;
         chk({31'h0, pslverr}, {31'h0, xe});
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : ap
   task key(input integer n);
      lvl <= 1'b1;
      cyc(n);
      lvl <= 1'b0;
      cyc(10);
   endtask : key
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lvl = 1'b0;
      mode = 1'b0;
      presetn = 1'b0;
      cyc(4);
      presetn <= 1'b1;
      cyc(1);
      chk({30'h0, tls}, 32'h1);
      ap(1'b0, `PRS_A_DISP, 32'h0, 1'b0);
      chk(rdat, 32'h3);
      ap(1'b1, `PRS_A_MVRST, 32'h0123, 1'b0);
      ap(1'b1, `PRS_A_PSEL, 32'h5, 1'b0);
      ap(1'b0, `PRS_A_POS, 32'h0, 1'b0);
      chk(rdat, 32'h00a00000);
      ap(1'b1, `PRS_A_CTRL, 32'h1, 1'b0);
      cyc(260);
      chk({31'h0, ctrl_on}, 32'h1);
      ap(1'b1, `PRS_A_PSEL, 32'h2, 1'b1);
      ap(1'b1, `PRS_A_CTRL, 32'h0, 1'b0);
      cyc(260);
      chk({31'h0, ctrl_on}, 32'h0);
      chk({16'h0, mv_out}, 32'h0123);
      ap(1'b1, `PRS_A_CTRL, 32'h5, 1'b0);
      cyc(260);
      chk({30'h0, sp_mode}, 32'h0);
      chk({31'h0, seg0}, 32'h1);
      ap(1'b1, `PRS_A_CTRL, 32'h4, 1'b0);
      cyc(260);
      chk({30'h0, sp_mode}, 32'h1);
      chk({31'h0, ctrl_on}, 32'h1);
      ap(1'b1, `PRS_A_START, 32'h3, 1'b1);
      for (i = 0; i < 8; i++) begin
         ap(1'b1, `PRS_A_DISP, i, 1'b0);
         cyc(4);
         chk({30'h0, tls}, {30'h0, M0[2*i+:2]});
         mode <= 1'b1;
         cyc(6);
         mode <= 1'b0;
         cyc(10);
         chk({30'h0, tls}, {30'h0, M1[2*i+:2]});
      end
      ap(1'b1, `PRS_A_CTRL, 32'h84, 1'b0);
      ap(1'b1, `PRS_A_DISP, 32'h4, 1'b0);
      cyc(4);
      chk({16'h0, tlv}, 32'h1111);
      ap(1'b1, `PRS_A_DISP, 32'h14, 1'b0);
      cyc(4);
      chk({16'h0, tlv}, 32'h2222);
      ap(1'b1, `PRS_A_CTRL, 32'h104, 1'b0);
      ap(1'b1, `PRS_A_DISP, 32'h4, 1'b0);
      cyc(4);
      chk({16'h0, tlv}, 32'h3333);
      ap(1'b0, 8'h30, 32'h0, 1'b1);
      chk(rdat, 32'h0);
      ap(1'b1, `PRS_A_STBY, 32'h5, 1'b0);
      ap(1'b1, `PRS_A_START, 32'h2, 1'b0);
      ap(1'b1, `PRS_A_CMD, 32'h1, 1'b0);
      cyc(260);
      ap(1'b0, `PRS_A_STAT, 32'h0, 1'b0);
      chk({29'h0, rdat[2:0]}, 32'h2);
      ap(1'b1, `PRS_A_CTRL, 32'h107, 1'b0);
      cyc(260);
      ap(1'b0, `PRS_A_STAT, 32'h0, 1'b0);
      chk({29'h0, rdat[2:0]}, 32'h4);
      ap(1'b1, `PRS_A_CTRL, 32'h105, 1'b0);
      cyc(260);
      ap(1'b0, `PRS_A_STAT, 32'h0, 1'b0);
      chk({29'h0, rdat[2:0]}, 32'h2);
      ap(1'b1, `PRS_A_START, 32'h1, 1'b0);
      key(50);
      chk({29'h0, menu_level}, 32'h2);
      ap(1'b1, `PRS_A_PASS, 32'hff57, 1'b0);
      cyc(45);
      chk({29'h0, menu_level}, 32'h4);
      key(30);
      chk({29'h0, menu_level}, 32'h2);
      key(30);
      chk({29'h0, menu_level}, 32'h1);
      cyc(260);
      ap(1'b0, `PRS_A_STAT, 32'h0, 1'b0);
      chk({29'h0, rdat[2:0]}, 32'h1);
      ap(1'b1, `PRS_A_MVMAN, 32'h0456, 1'b0);
      ap(1'b1, `PRS_A_CTRL, 32'hc, 1'b0);
      ap(1'b1, `PRS_A_START, 32'h3, 1'b0);
      ap(1'b1, `PRS_A_CMD, 32'h1, 1'b0);
      cyc(260);
      chk({16'h0, mv_out}, 32'h0);
      ap(1'b1, `PRS_A_CTRL, 32'h18, 1'b0);
      cyc(4);
      chk({16'h0, mv_out}, 32'h0456);
      chk(n_atc, 32'h3);
      final_report();
   end
endmodule : tb_program_run_reset_sequencer
